/* rtl/lft_ctrl_regs.svh */
// register indices, field positions, reset values and timing counts of the flash/torch control block
`ifndef LFT_CTRL_REGS_SVH
`define LFT_CTRL_REGS_SVH

`define LFT_IDX_LED_SELECT     8'h01
`define LFT_IDX_PUMP_MODE_TRIG 8'h02
`define LFT_IDX_LED1_PEAK      8'h03
`define LFT_IDX_LED2_PEAK      8'h04
`define LFT_IDX_TORCH_CURRENT  8'h05
`define LFT_IDX_LED1_DELAY     8'h07
`define LFT_IDX_LED2_DELAY     8'h08
`define LFT_IDX_LED1_WIDTH     8'h0A
`define LFT_IDX_LED2_WIDTH     8'h0B
`define LFT_IDX_VOUT           8'h0F
`define LFT_IDX_TIMEOUT        8'h14

`define LFT_B_LED1_SEL   0
`define LFT_B_LED2_SEL   1
`define LFT_B_LED_CHECK  4
`define LFT_B_PHOTO      5
`define LFT_B_IND_EN     0
`define LFT_B_PRECHARGE  1
`define LFT_B_PUMP_EN    2
`define LFT_B_SW_TRIG    4
`define LFT_B_FLASH_MODE 5
`define LFT_B_PUMP_HOLD  6

`define LFT_REG_RESET    8'h00
`define LFT_TORCH_LIMIT  8'h3F
`define LFT_FLASH_TIMEOUT_SETTING_DEF_MS  8'h32
`define LFT_TICK_US      1000
`define LFT_CLK_MHZ      200

`endif

/* rtl/lft_ctrl_pkg.sv */
// types shared by the flash/torch control block and its bench
package lft_ctrl_pkg;

  typedef enum logic [3:0] {
    LFT_IDLE  = 4'b0001,
    LFT_DELAY = 4'b0010,
    LFT_PULSE = 4'b0100,
    LFT_DONE  = 4'b1000
  } lft_seq_t;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] idx;
    logic [7:0] data;
  } lft_wr_t;

  typedef struct packed {
    logic [1:0]      gateOn;
    logic [1:0][7:0] peakCode;
    logic [1:0]      torchOn;
    logic [7:0]      torchCode;
    logic            indicatorOn;
    logic            pumpOn;
    logic            preChargeOn;
    logic            photoSenseOn;
    logic            ledCheckOn;
    logic            timeoutArmed;
    logic            timeoutHit;
    logic [7:0]      voutCode;
  } lft_drive_t;

endpackage

/* rtl/lft_ctrl.sv */
// register bank and flash/torch/indicator mode control of a dual LED flash driver
`timescale 1ns/1ps
`include "lft_ctrl_regs.svh"

module lft_ctrl
  import lft_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = `LFT_TICK_US * `LFT_CLK_MHZ
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire lft_wr_t    regWr,
  input  wire logic [7:0] regRdIdx,
  output logic [7:0]      regRdData,
  output lft_drive_t      drive
);

  localparam int DIVW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [7:0]      ledSel;
    logic [7:0]      pumpCfg;
    logic [1:0][7:0] peak;
    logic [1:0][7:0] dly;
    logic [1:0][7:0] wid;
    logic [7:0]      vout;
    logic [7:0]      flash_timeout_setting;
    logic [7:0]      torch;
    logic [DIVW-1:0] divCnt;
    lft_seq_t [1:0]  seq;
    logic [1:0][7:0] cnt;
    logic [7:0]      toCnt;
    logic            flashActive;
    logic            torchTimedOut;
    logic [7:0]      rdData;
    lft_drive_t      out;
  } lft_state_t;

  lft_state_t q;
  lft_state_t d;

  logic       tick;
  logic       wrCfg;
  logic       fire;
  logic       abort;
  logic       anyPulse;
  logic       allDone;
  logic       torchMode;
  logic       torchOver;
  logic [7:0] toutEff;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    d = q;
    tick = (q.divCnt == DIV_LAST);
    d.divCnt = tick ? '0 : q.divCnt + 1'b1;
    // a zero time-out setting falls back to the default so a cleared register does not cut a flash at its first tick
    toutEff = (q.flash_timeout_setting == `LFT_REG_RESET) ? `LFT_FLASH_TIMEOUT_SETTING_DEF_MS : q.flash_timeout_setting;
    anyPulse = (q.seq[0] == LFT_PULSE) || (q.seq[1] == LFT_PULSE);
    allDone = (q.seq[0] == LFT_DONE) && (q.seq[1] == LFT_DONE);
    wrCfg = regWr.wrEn && (regWr.idx == `LFT_IDX_PUMP_MODE_TRIG);
    fire = wrCfg && regWr.data[`LFT_B_SW_TRIG] && !q.pumpCfg[`LFT_B_SW_TRIG]
        && regWr.data[`LFT_B_FLASH_MODE] && (q.ledSel[1:0] != 2'b00);
    abort = wrCfg && (!regWr.data[`LFT_B_SW_TRIG] || !regWr.data[`LFT_B_FLASH_MODE]);
    d.out.timeoutHit = 1'b0;

    // flash sequencer, one delay then one pulse per selected LED
    if (q.flashActive && allDone)
    begin
      d.flashActive = 1'b0;
      d.seq = {LFT_IDLE, LFT_IDLE};
      d.pumpCfg[`LFT_B_SW_TRIG] = 1'b0;
    end
    else if (q.flashActive)
    begin
      for (int i = 0; i < 2; i++)
      begin
        unique case (q.seq[i])
          LFT_DELAY:
          begin
            // leave on the tick so the pulse starts on a tick boundary and lasts whole ticks
            if (tick && q.cnt[i] <= 8'h01)
            begin
              d.seq[i] = LFT_PULSE;
              d.cnt[i] = q.wid[i];
            end
            else if (tick)
            begin
              d.cnt[i] = q.cnt[i] - 8'h01;
            end
          end
          LFT_PULSE:
          begin
            if (tick && q.cnt[i] <= 8'h01)
            begin
              d.seq[i] = LFT_DONE;
            end
            else if (tick)
            begin
              d.cnt[i] = q.cnt[i] - 8'h01;
            end
          end
          LFT_IDLE, LFT_DONE:
          begin
            d.seq[i] = LFT_DONE;
          end
        endcase
      end
      if (anyPulse && tick)
      begin
        if (q.toCnt <= 8'h01)
        begin
          d.seq = {LFT_DONE, LFT_DONE};
          d.out.timeoutHit = 1'b1;
        end
        else
        begin
          d.toCnt = q.toCnt - 8'h01;
        end
      end
    end

    // torch time-out: runs only while torch current is above the mirror limit
    torchMode = !q.pumpCfg[`LFT_B_FLASH_MODE];
    torchOver = torchMode && !q.pumpCfg[`LFT_B_IND_EN] && (q.ledSel[1:0] != 2'b00)
             && (q.torch > `LFT_TORCH_LIMIT);
    if (!q.flashActive)
    begin
      if (!torchOver)
      begin
        d.toCnt = toutEff;
      end
      else if (tick && !q.torchTimedOut)
      begin
        if (q.toCnt <= 8'h01)
        begin
          d.torchTimedOut = 1'b1;
          d.out.timeoutHit = 1'b1;
        end
        else
        begin
          d.toCnt = q.toCnt - 8'h01;
        end
      end
    end

    // software writes come last so a write landing with the self-clear wins
    if (regWr.wrEn)
    begin
      case (regWr.idx)
        `LFT_IDX_LED_SELECT:     d.ledSel = regWr.data;
        `LFT_IDX_PUMP_MODE_TRIG: d.pumpCfg = regWr.data;
        `LFT_IDX_LED1_PEAK:      d.peak[0] = regWr.data;
        `LFT_IDX_LED2_PEAK:      d.peak[1] = regWr.data;
        `LFT_IDX_TORCH_CURRENT:  d.torch = regWr.data;
        `LFT_IDX_LED1_DELAY:     d.dly[0] = regWr.data;
        `LFT_IDX_LED2_DELAY:     d.dly[1] = regWr.data;
        `LFT_IDX_LED1_WIDTH:     d.wid[0] = regWr.data;
        `LFT_IDX_LED2_WIDTH:     d.wid[1] = regWr.data;
        `LFT_IDX_VOUT:           d.vout = regWr.data;
        `LFT_IDX_TIMEOUT:        d.flash_timeout_setting = regWr.data;
        default:                 d.vout = q.vout;
      endcase
      // a fresh torch setting or mode write re-arms a tripped torch
      if (wrCfg || regWr.idx == `LFT_IDX_TORCH_CURRENT)
      begin
        // a trip landing in this same cycle wins over the re-arm
        d.torchTimedOut = d.torchTimedOut && !q.torchTimedOut;
        // reload, else a re-armed torch would trip again at the very next tick
        if (!q.flashActive)
        begin
          d.toCnt = toutEff;
        end
      end
    end

    if (abort)
    begin
      d.flashActive = 1'b0;
      d.seq = {LFT_IDLE, LFT_IDLE};
    end
    else if (fire)
    begin
      d.flashActive = 1'b1;
      d.divCnt = '0;
      d.toCnt = toutEff;
      for (int i = 0; i < 2; i++)
      begin
        // a zero delay goes straight to the pulse so no cycle is lost before it
        d.seq[i] = !q.ledSel[i] ? LFT_DONE : (q.dly[i] == 8'h00) ? LFT_PULSE : LFT_DELAY;
        d.cnt[i] = (q.dly[i] == 8'h00) ? q.wid[i] : q.dly[i];
      end
    end

    unique case (regRdIdx)
      `LFT_IDX_LED_SELECT:     d.rdData = q.ledSel;
      `LFT_IDX_PUMP_MODE_TRIG: d.rdData = q.pumpCfg;
      `LFT_IDX_LED1_PEAK:      d.rdData = q.peak[0];
      `LFT_IDX_LED2_PEAK:      d.rdData = q.peak[1];
      `LFT_IDX_TORCH_CURRENT:  d.rdData = q.torch;
      `LFT_IDX_LED1_DELAY:     d.rdData = q.dly[0];
      `LFT_IDX_LED2_DELAY:     d.rdData = q.dly[1];
      `LFT_IDX_LED1_WIDTH:     d.rdData = q.wid[0];
      `LFT_IDX_LED2_WIDTH:     d.rdData = q.wid[1];
      `LFT_IDX_VOUT:           d.rdData = q.vout;
      `LFT_IDX_TIMEOUT:        d.rdData = q.flash_timeout_setting;
      default:                 d.rdData = 8'h00;
    endcase

    // drive outputs follow the next state so they change with it
    for (int i = 0; i < 2; i++)
    begin
      d.out.gateOn[i] = d.flashActive && (d.seq[i] == LFT_PULSE);
      d.out.peakCode[i] = d.peak[i];
      d.out.torchOn[i] = !d.pumpCfg[`LFT_B_FLASH_MODE] && d.ledSel[i]
                      && !d.pumpCfg[`LFT_B_IND_EN] && !d.torchTimedOut;
    end
    d.out.torchCode = d.torch;
    d.out.indicatorOn = d.pumpCfg[`LFT_B_IND_EN];
    d.out.pumpOn = d.pumpCfg[`LFT_B_PUMP_EN]
                && (!d.flashActive || d.pumpCfg[`LFT_B_PUMP_HOLD]);
    d.out.preChargeOn = d.pumpCfg[`LFT_B_PRECHARGE];
    d.out.photoSenseOn = d.ledSel[`LFT_B_PHOTO];
    d.out.ledCheckOn = d.ledSel[`LFT_B_LED_CHECK] && d.flashActive;
    d.out.timeoutArmed = d.flashActive
                      || (d.out.torchOn != 2'b00 && d.torch > `LFT_TORCH_LIMIT);
    d.out.voutCode = d.vout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset leaves every LED, the pump and the trigger off

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.seq <= {LFT_IDLE, LFT_IDLE};
    end
    else
    begin
      q <= d;
    end
  end

  assign regRdData = q.rdData;
  assign drive = q.out;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_FIRE_STARTS: assert property (
    fire |=> q.flashActive && (q.seq[0] != LFT_IDLE))
    else $error("software trigger edge did not start a flash");

  AST_ZERO_ABORTS: assert property (
    regWr.wrEn && regWr.idx == `LFT_IDX_PUMP_MODE_TRIG && !regWr.data[`LFT_B_SW_TRIG]
    |=> !q.flashActive && drive.gateOn == 2'b00)
    else $error("writing trigger low did not clear the sequence");

  AST_TRIG_SELF_CLEAR: assert property (
    q.flashActive && allDone && !wrCfg |=> !q.pumpCfg[`LFT_B_SW_TRIG] && !q.flashActive)
    else $error("trigger bit not cleared after the pulse");

  AST_TORCH_GATES_OFF: assert property (
    !q.pumpCfg[`LFT_B_FLASH_MODE] |-> drive.gateOn == 2'b00)
    else $error("gate drive on in torch mode");

  AST_IND_SUSPENDS_TORCH: assert property (
    drive.indicatorOn |-> drive.torchOn == 2'b00)
    else $error("torch active while indicator on");

  AST_TORCH_RESUMES: assert property (
    $fell(q.pumpCfg[`LFT_B_IND_EN]) && !q.pumpCfg[`LFT_B_FLASH_MODE] && !q.torchTimedOut
    |-> drive.torchOn == q.ledSel[1:0])
    else $error("torch state not restored after indicator");

  AST_TORCH_TIMEOUT_ARM: assert property (
    drive.torchOn != 2'b00 && q.torch > `LFT_TORCH_LIMIT |-> drive.timeoutArmed)
    else $error("time-out not armed for high torch current");

  AST_TORCH_NO_TIMEOUT: assert property (
    !q.flashActive && q.torch <= `LFT_TORCH_LIMIT |-> !drive.timeoutArmed)
    else $error("time-out armed in low-current torch mode");

  AST_PUMP_STOPS: assert property (
    q.flashActive && !q.pumpCfg[`LFT_B_PUMP_HOLD] |-> !drive.pumpOn)
    else $error("pump running during pulse while told to stop");

  AST_PEAK_READBACK: assert property (
    regWr.wrEn && regWr.idx == `LFT_IDX_LED1_PEAK ##1 (!regWr.wrEn && regRdIdx == `LFT_IDX_LED1_PEAK)
    |=> regRdData == $past(regWr.data, 2))
    else $error("led1 peak register read back wrong");

  AST_FLASH_NO_TORCH: assert property (
    q.pumpCfg[`LFT_B_FLASH_MODE] |-> drive.torchOn == 2'b00)
    else $error("torch mirrors on in flash mode");

  AST_IDLE_GATES_OFF: assert property (
    !q.flashActive |-> drive.gateOn == 2'b00)
    else $error("gate drive on with no flash sequence");

  AST_TIMEOUT_CUTS_PULSE: assert property (
    q.flashActive && drive.timeoutHit |-> drive.gateOn == 2'b00)
    else $error("flash pulse still on after time-out");

  AST_TORCH_TRIP_OFF: assert property (
    $rose(q.torchTimedOut) |-> drive.timeoutHit && drive.torchOn == 2'b00)
    else $error("torch time-out expired without cutting the torch");

  AST_CHECK_ONLY_IN_FLASH: assert property (
    drive.ledCheckOn |-> q.flashActive && q.ledSel[`LFT_B_LED_CHECK])
    else $error("led check running outside a flash");

  COV_FLASH_DONE: cover property (q.flashActive ##1 !q.flashActive && !q.pumpCfg[`LFT_B_SW_TRIG]);
  COV_FLASH_TIMEOUT: cover property (q.flashActive && drive.timeoutHit);
  COV_TORCH_TRIP: cover property ($rose(q.torchTimedOut));
  COV_IND_WITH_FLASH: cover property (drive.indicatorOn && drive.gateOn[0]);

endmodule // lft_ctrl

/* dv/lft_ctrl_host.sv */
// host model: register writes and reads as the serial slave would hand them over
`timescale 1ns/1ps
module lft_ctrl_host
  import lft_ctrl_pkg::*;
(
  input  wire logic       clk_sys,
  output lft_wr_t         regWr,
  output logic [7:0]      regRdIdx,
  input  wire logic [7:0] regRdData
);
  initial
  begin
    regWr    = '0;
    regRdIdx = 8'h00;
  end
  ////////////////////////////////////////
  // one addressed write: index and data byte travel together
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(negedge clk_sys);
    regWr <= '{1'b1, idx, dat};
    @(negedge clk_sys);
    regWr.wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
    @(negedge clk_sys);
    regRdIdx <= idx;
    @(negedge clk_sys);
    dat = regRdData;
  endtask
  // clear the old sequence first, else the trigger sees no rising edge
  task automatic fire(input logic [7:0] base);
    wr(8'h02, base);
    wr(8'h02, base | 8'h10);
  endtask
endmodule // lft_ctrl_host

/* dv/lft_ctrl_tb.sv */
// self-checking bench of the flash/torch control block
`timescale 1ns/1ps
module lft_ctrl_tb;
  import lft_ctrl_pkg::*;
  // short tick keeps flash timing in tens of cycles
  localparam int TICK = 4;
  localparam logic [7:0] IDX [11] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
                                      8'h0A, 8'h0B, 8'h0F, 8'h14, 8'h06};
  logic       clk_sys;
  logic       rst_n;
  lft_wr_t    regWr;
  logic [7:0] regRdIdx;
  logic [7:0] regRdData;
  lft_drive_t drive;
  logic [7:0] r;
  int         errCount = 0;
  int         nCompared = 0;

  lft_ctrl #(.TICK_CYCLES(TICK)) DUT (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .regWr     (regWr),
    .regRdIdx  (regRdIdx),
    .regRdData (regRdData),
    .drive     (drive)
  );
  lft_ctrl_host HOST (
    .clk_sys   (clk_sys),
    .regWr     (regWr),
    .regRdIdx  (regRdIdx),
    .regRdData (regRdData)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH %0t %s: %0h vs %0h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk(drive, '0, "drive at reset");
    foreach (IDX[i])
    begin
      HOST.rd(IDX[i], r);
      chk(r, 8'h00, "reset value");
    end
    HOST.rd(8'h02, r);
    chk(r, 8'h00, "reset cfg");
  endtask
  // last table entry is unmapped and must stay zero
  task automatic t_map;
    foreach (IDX[i])
      HOST.wr(IDX[i], IDX[i] ^ 8'hA5);
    foreach (IDX[i])
    begin
      HOST.rd(IDX[i], r);
      chk(r, i == 10 ? 8'h00 : IDX[i] ^ 8'hA5, "readback");
    end
    chk(drive.peakCode, {8'h04 ^ 8'hA5, 8'h03 ^ 8'hA5}, "peak");
    chk(drive.voutCode, 8'h0F ^ 8'hA5, "vout");
    chk({drive.photoSenseOn, drive.ledCheckOn}, 2'b10, "photo");
    foreach (IDX[i])
      HOST.wr(IDX[i], 8'h00);
  endtask
  task automatic t_torch;
    HOST.wr(8'h0F, 8'h00);
    HOST.wr(8'h01, 8'h03);
    HOST.wr(8'h05, 8'h3F);
    HOST.wr(8'h02, 8'h06);
    chk({drive.torchOn, drive.gateOn, drive.timeoutArmed}, 5'b11_00_0, "torch");
    chk({drive.pumpOn, drive.preChargeOn}, 2'b11, "pump on");
    HOST.wr(8'h05, 8'h40);
    chk({drive.torchCode, drive.timeoutArmed}, {8'h40, 1'b1}, "torch arm");
    HOST.wr(8'h02, 8'h07);
    chk({drive.torchOn, drive.indicatorOn, drive.gateOn}, 5'b00_1_00, "ind");
    HOST.wr(8'h02, 8'h06);
    chk({drive.torchOn, drive.indicatorOn}, 3'b11_0, "torch back");
    HOST.wr(8'h02, 8'h00);
    chk({drive.pumpOn, drive.preChargeOn}, 2'b00, "pump off");
    HOST.wr(8'h05, 8'h00);
  endtask
  // both leds, led1 delayed one tick, widths of two and four ticks
  task automatic t_flash(input logic [7:0] base);
    int   n0 = 0;
    int   n1 = 0;
    logic ck = 1'b0;
    logic ta = 1'b0;
    HOST.wr(8'h01, 8'h13);
    HOST.wr(8'h07, 8'h01);
    HOST.wr(8'h0A, 8'h02);
    HOST.wr(8'h0B, 8'h04);
    HOST.fire(base);
    // sample first: the gate may already be up in the cycle right after the trigger write
    repeat (12 * TICK)
    begin
      n0 += drive.gateOn[0];
      n1 += drive.gateOn[1];
      ck |= drive.ledCheckOn;
      ta |= drive.timeoutArmed;
      if (drive.gateOn != 2'b00)
        chk({drive.pumpOn, drive.indicatorOn, drive.torchOn}, {base[6], base[0], 2'b00}, "pulse");
      @(negedge clk_sys);
    end
    chk(n0, 2 * TICK, "led1 width");
    chk(n1, 4 * TICK, "led2 width");
    chk({ck, ta}, 2'b11, "check, timeout");
    HOST.rd(8'h02, r);
    chk(r, base, "trigger clear");
    chk({drive.gateOn, drive.ledCheckOn}, 3'b000, "idle");
  endtask
  // torch trip after two ticks, re-arm by a fresh write, then a flash cut by a one-tick time-out
  task automatic t_trip;
    int n0 = 0;
    int h0 = 0;
    int h1 = 0;
    HOST.wr(8'h14, 8'h02);
    HOST.wr(8'h05, 8'h40);
    repeat (TICK)
    begin
      h0 += drive.timeoutHit;
      @(negedge clk_sys);
    end
    repeat (2 * TICK)
    begin
      h1 += drive.timeoutHit;
      @(negedge clk_sys);
    end
    chk({h0, h1}, {32'd0, 32'd1}, "torch trip");
    chk({drive.torchOn, drive.timeoutArmed}, 3'b00_0, "tripped");
    HOST.wr(8'h05, 8'h40);
    repeat (TICK) @(negedge clk_sys);
    chk(drive.torchOn, 2'b11, "re-armed");
    HOST.wr(8'h05, 8'h00);
    HOST.wr(8'h01, 8'h01);
    HOST.wr(8'h14, 8'h01);
    HOST.wr(8'h0A, 8'h10);
    HOST.fire(8'h66);
    h1 = 0;
    repeat (4 * TICK)
    begin
      n0 += drive.gateOn[0];
      h1 += drive.timeoutHit;
      @(negedge clk_sys);
    end
    chk({n0, h1}, {TICK, 32'd1}, "flash trip");
    HOST.wr(8'h14, 8'h00);
  endtask
  task automatic t_abort;
    HOST.fire(8'h66);
    repeat (2 * TICK) @(negedge clk_sys);
    chk(drive.gateOn, 2'b11, "running");
    HOST.wr(8'h02, 8'h66);
    // registered gate output drops on the same edge that takes the abort
    @(negedge clk_sys);
    chk(drive.gateOn, 2'b00, "aborted");
    HOST.rd(8'h02, r);
    chk(r, 8'h66, "disarmed");
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_map();
    t_torch();
    t_trip();
    t_flash(8'h66);
    t_flash(8'h27);
    t_abort();
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errCount++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // lft_ctrl_tb
